// ===== rtl/ifcc_cond_det.sv
// Noise filter and start and stop condition detector.
`timescale 1ns/10ps
`default_nettype none
module ifcc_cond_det #(
    parameter int FILT = ifcc_pkg::FILT_CYC // Filter length in cycles.
) (
    input wire logic pclk, // Peripheral clock.
    input wire logic presetn, // Asynchronous reset, active low.
    input wire logic filt_en, // Noise filter switched in.
    input wire logic scl_s, // Synchronised serial clock.
    input wire logic sda_s, // Synchronised serial data.
    output logic scl_lvl, // Filtered serial clock level.
    output logic sda_lvl, // Filtered serial data level.
    output logic start_p, // Start condition seen, one cycle.
    output logic stop_p // Stop condition seen, one cycle.
);
    typedef struct packed {
        logic scl;
        logic sda;
        logic [3:0] cscl;
        logic [3:0] csda;
        logic st;
        logic sp;
    } ifcc_det_t;
    ifcc_det_t q, d;

    // With filt_en high, a level is taken only after it has differed for FILT cycles; with it low, at once.
    always_comb
    begin
        d = q;
        d.cscl = (scl_s != q.scl) ? q.cscl + 4'h1 : 4'h0;
        d.csda = (sda_s != q.sda) ? q.csda + 4'h1 : 4'h0;
        if (!filt_en || (scl_s != q.scl && q.cscl >= 4'(FILT - 1)))
            d.scl = scl_s;
        if (!filt_en || (sda_s != q.sda && q.csda >= 4'(FILT - 1)))
            d.sda = sda_s;
        if (d.scl != q.scl)
            d.cscl = 4'h0;
        if (d.sda != q.sda)
            d.csda = 4'h0;
        // Data moving while the clock stays high marks a condition.
        d.st = q.scl & d.scl & q.sda & ~d.sda;
        d.sp = q.scl & d.scl & ~q.sda & d.sda;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            q <= '0;
            q.scl <= 1'b1;
            q.sda <= 1'b1;
        end
        else
            q <= d;
    end

    assign scl_lvl = q.scl;
    assign sda_lvl = q.sda;
    assign start_p = q.st;
    assign stop_p = q.sp;
endmodule
`default_nettype wire

// ===== rtl/ifcc_pkg.sv
// Package with the register map, field layout and timing of the block.
package ifcc_pkg;
    // Register indices; the byte address is four times the index.
    localparam logic [15:0] TCS_IDX = 16'hffa8;
    localparam logic [15:0] FX_IDX = 16'hffa9;
    localparam logic [15:0] FLAG_IDX = 16'hffab;
    localparam logic [15:0] CTRL_IDX = 16'hffa6;
    localparam logic [15:0] STAT_IDX = 16'hffaa;
    localparam int ADDR_W = 18;
    localparam logic [7:0] REG_RESET = 8'h00;
    // Flag register fields.
    localparam int F_FAIL = 7;
    localparam int F_BUSY = 6;
    localparam int F_INIT = 1;
    localparam int F_RSV = 0;
    // Transfer clock select fields.
    localparam int C_CLD = 5;
    localparam int C_DAD = 4;
    localparam int C_SMC = 3;
    localparam int C_DFC = 2;
    localparam int C_CLHI = 1;
    localparam int C_CLLO = 0;
    localparam int X_CLX = 0;
    // Control and status fields.
    localparam int K_OPEN = 7;
    localparam int K_STREQ = 1;
    localparam int S_STD = 1;
    localparam int S_SPD = 0;
    // Clock and timing.
    localparam int CLK_PERIOD_NS = 100;
    localparam int HOLD_NS = 4000;
    localparam int HOLD_CYC = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FILT_NS = 200;
    localparam int FILT_CYC = (FILT_NS / CLK_PERIOD_NS < 1) ? 1 :
        FILT_NS / CLK_PERIOD_NS;
    // Peripheral clock cycles per transfer clock period (prescale times m).
    localparam logic [8:0] DIV_N44 = 9'h058;
    localparam logic [8:0] DIV_N86 = 9'h0ac;
    localparam logic [8:0] DIV_N86S = 9'h158;
    localparam logic [8:0] DIV_H24 = 9'h030;
    localparam logic [8:0] DIV_H24S = 9'h060;
    localparam logic [8:0] DIV_H12 = 9'h018;
    localparam logic [8:0] DIV_BAD = 9'h000;
    // Start generator states.
    typedef enum logic [2:0] {
        GEN_IDLE = 3'b001,
        GEN_HOLD = 3'b010,
        GEN_OWN = 3'b100
    } ifcc_gen_t;
endpackage

// ===== rtl/ifcc_sync.sv
// Two-stage synchroniser for the serial clock and data pins.
`timescale 1ns/10ps
`default_nettype none
module ifcc_sync (
    input wire logic pclk, // Peripheral clock.
    input wire logic presetn, // Asynchronous reset, active low.
    input wire logic [1:0] async_in, // Pin levels from outside.
    output logic [1:0] sync_out // Levels safe to use.
);
    typedef struct packed {
        logic [1:0] s1;
        logic [1:0] s2;
    } ifcc_sync_t;
    ifcc_sync_t q, d;

    // The first stage feeds only the second stage.
    always_comb
    begin
        d.s1 = async_in;
        d.s2 = q.s1;
    end

    // Idle bus lines are high, so reset to high.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            q <= 4'hf;
        else
            q <= d;
    end

    assign sync_out = q.s2;
endmodule
`default_nettype wire

// ===== rtl/ifcc_top.sv
// Flag, transfer clock select and expansion registers of the I2C block.
//
// Design decision made here: the APB slave port.
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - Flag register writable, but fail and busy flags are read-only.
// - Reservation-disable and initial start bits locked while enabled.
// - Reset clears the whole flag register.
// - Reservation off and start impossible: drop request, set fail flag.
// - Busy sets on start detection or enabling with initial start off.
// - Busy clears on stop or disable; starts 0 if initial start on.
// - Initial start off needs a stop first; stop clears the bit.
// - Reservation-disable bit changes only by software or reset.
// - Clock select writable; line level bits read-only; top bits read 0.
// - Clock level bit follows the clock pin while enabled, else 0.
// - Data level bit follows the data pin while enabled, else 0.
// - Speed mode bit picks standard (0) or high-speed (1).
// - Filter bit turns the noise filter on; high-speed only; same clock.
// - Transfer clock chosen by speed, two select bits and extension bit.
// - Clock settings fixed before enabling; change needs disable first.
// - Start request after a stop outputs a start; start sets status.
module ifcc_top (
    input wire logic pclk, // Peripheral clock, 10 MHz.
    input wire logic presetn, // Asynchronous reset, active low.
    input wire logic psel, // APB select.
    input wire logic penable, // APB enable.
    input wire logic pwrite, // APB write.
    input wire logic [ifcc_pkg::ADDR_W-1:0] paddr, // APB byte address.
    input wire logic [31:0] pwdata, // APB write data.
    output logic [31:0] prdata, // APB read data.
    output logic pready, // APB ready.
    output logic pslverr, // APB error on unmapped address.
    input wire logic scl_i, // Serial clock pin level.
    output logic scl_o, // Serial clock drive value, always low.
    output logic scl_oe, // Serial clock pulled low.
    input wire logic sda_i, // Serial data pin level.
    output logic sda_o, // Serial data drive value, always low.
    output logic sda_oe, // Serial data pulled low.
    output logic [8:0] clk_div, // Cycles per transfer clock, 0 if barred.
    output logic filt_on // Noise filter in use.
);
    typedef struct packed {
        logic op_en;
        logic start_req;
        logic fail;
        logic busy;
        logic init_start;
        logic rsv_dis;
        logic cld;
        logic dad;
        logic smc;
        logic dfc;
        logic [1:0] clsel;
        logic clx;
        logic std;
        logic spd;
        ifcc_pkg::ifcc_gen_t gen;
        logic [5:0] hcnt;
        logic sda_oe;
        logic scl_oe;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic [8:0] div;
        logic filt;
    } ifcc_state_t;
    ifcc_state_t q, d;

    logic [1:0] pins_s;
    logic scl_lvl;
    logic sda_lvl;
    logic start_p;
    logic stop_p;
    logic [15:0] idx;
    logic wr;
    logic wr_tcs;
    logic wr_fx;
    logic wr_flag;
    logic wr_ctrl;
    logic allowed;

    // Cycles per transfer clock from speed, extension and select bits.
    function automatic logic [8:0] div_of(input logic smc, input logic clx,
        input logic [1:0] cl);
        logic [8:0] r;
        r = ifcc_pkg::DIV_BAD;
        if (!smc && !clx)
        begin
            case (cl)
                2'h0: r = ifcc_pkg::DIV_N44;
                2'h1: r = ifcc_pkg::DIV_N86;
                2'h2: r = ifcc_pkg::DIV_N86S;
                default: r = ifcc_pkg::DIV_BAD;
            endcase
        end
        else if (smc && !clx)
            r = cl[0] ? ifcc_pkg::DIV_H24S : ifcc_pkg::DIV_H24;
        else if (smc && clx)
            r = cl[0] ? ifcc_pkg::DIV_H24 : ifcc_pkg::DIV_H12;
        return r;
    endfunction

    // Read value of a mapped register; unmapped indices return zero.
    function automatic logic [7:0] rd_of(input logic [15:0] i,
        input ifcc_state_t s);
        logic [7:0] v;
        v = 8'h00;
        case (i)
            ifcc_pkg::TCS_IDX:
            begin
                v[ifcc_pkg::C_CLD] = s.cld;
                v[ifcc_pkg::C_DAD] = s.dad;
                v[ifcc_pkg::C_SMC] = s.smc;
                v[ifcc_pkg::C_DFC] = s.dfc;
                v[ifcc_pkg::C_CLHI] = s.clsel[1];
                v[ifcc_pkg::C_CLLO] = s.clsel[0];
            end
            ifcc_pkg::FX_IDX: v[ifcc_pkg::X_CLX] = s.clx;
            ifcc_pkg::FLAG_IDX:
            begin
                v[ifcc_pkg::F_FAIL] = s.fail;
                v[ifcc_pkg::F_BUSY] = s.busy;
                v[ifcc_pkg::F_INIT] = s.init_start;
                v[ifcc_pkg::F_RSV] = s.rsv_dis;
            end
            ifcc_pkg::CTRL_IDX:
            begin
                v[ifcc_pkg::K_OPEN] = s.op_en;
                v[ifcc_pkg::K_STREQ] = s.start_req;
            end
            ifcc_pkg::STAT_IDX:
            begin
                v[ifcc_pkg::S_STD] = s.std;
                v[ifcc_pkg::S_SPD] = s.spd;
            end
            default: v = 8'h00;
        endcase
        return v;
    endfunction

    ifcc_sync u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in({scl_i, sda_i}),
        .sync_out(pins_s)
    );

    ifcc_cond_det u_det (
        .pclk(pclk),
        .presetn(presetn),
        .filt_en(q.filt),
        .scl_s(pins_s[1]),
        .sda_s(pins_s[0]),
        .scl_lvl(scl_lvl),
        .sda_lvl(sda_lvl),
        .start_p(start_p),
        .stop_p(stop_p)
    );

    // Bus decode: a write lands in the single access cycle.
    assign idx = paddr[ifcc_pkg::ADDR_W-1:2];
    assign wr = psel & penable & q.pready & pwrite;
    assign wr_tcs = wr && idx == ifcc_pkg::TCS_IDX;
    assign wr_fx = wr && idx == ifcc_pkg::FX_IDX;
    assign wr_flag = wr && idx == ifcc_pkg::FLAG_IDX;
    assign wr_ctrl = wr && idx == ifcc_pkg::CTRL_IDX;
    assign allowed = q.op_en & ~q.busy & (q.init_start | q.spd);

    // Next state of the whole block.
    always_comb
    begin
        d = q;
        // Answer in the cycle after setup; read data sampled at setup.
        d.pready = psel & ~penable;
        d.pslverr = psel & ~penable & idx != ifcc_pkg::TCS_IDX
            & idx != ifcc_pkg::FX_IDX & idx != ifcc_pkg::FLAG_IDX
            & idx != ifcc_pkg::CTRL_IDX & idx != ifcc_pkg::STAT_IDX;
        if (psel && !penable)
            d.prdata = {24'h000000, rd_of(idx, q)};
        // Clock settings only move while disabled.
        if (wr_tcs && !q.op_en)
        begin
            d.smc = pwdata[ifcc_pkg::C_SMC];
            d.dfc = pwdata[ifcc_pkg::C_DFC];
            d.clsel = {pwdata[ifcc_pkg::C_CLHI], pwdata[ifcc_pkg::C_CLLO]};
        end
        if (wr_fx && !q.op_en)
            d.clx = pwdata[ifcc_pkg::X_CLX];
        // Control: enable and start request.
        if (wr_ctrl)
        begin
            d.op_en = pwdata[ifcc_pkg::K_OPEN];
            if (pwdata[ifcc_pkg::K_STREQ])
            begin
                d.start_req = 1'b1;
                d.fail = 1'b0;
            end
        end
        if (!d.op_en)
        begin
            d.start_req = 1'b0;
            d.fail = 1'b0;
        end
        // Stop detection ends the initial start allowance.
        if (stop_p)
            d.init_start = 1'b0;
        if (wr_flag && !q.op_en)
        begin
            d.init_start = pwdata[ifcc_pkg::F_INIT];
            d.rsv_dis = pwdata[ifcc_pkg::F_RSV];
        end
        // Bus busy: sets win over clears.
        if (stop_p || !d.op_en)
            d.busy = 1'b0;
        if ((start_p && q.op_en) || (d.op_en && !q.op_en && !q.init_start))
            d.busy = 1'b1;
        // Condition status bits.
        if (start_p)
        begin
            d.std = 1'b1;
            d.spd = 1'b0;
        end
        if (stop_p)
        begin
            d.spd = 1'b1;
            d.std = 1'b0;
        end
        if (!q.op_en)
        begin
            d.std = 1'b0;
            d.spd = 1'b0;
        end
        // Pin level bits follow the lines only while enabled.
        d.cld = q.op_en & scl_lvl;
        d.dad = q.op_en & sda_lvl;
        d.div = div_of(q.smc, q.clx, q.clsel);
        d.filt = q.smc & q.dfc;
        // Start generator.
        case (q.gen)
            ifcc_pkg::GEN_IDLE:
            begin
                if (q.start_req && d.op_en)
                begin
                    if (allowed)
                    begin
                        d.gen = ifcc_pkg::GEN_HOLD;
                        d.sda_oe = 1'b1;
                        d.hcnt = 6'h00;
                    end
                    else if (q.rsv_dis)
                    begin
                        d.start_req = 1'b0;
                        d.fail = 1'b1;
                    end
                end
            end
            ifcc_pkg::GEN_HOLD:
            begin
                d.hcnt = q.hcnt + 6'h01;
                if (q.hcnt == 6'(ifcc_pkg::HOLD_CYC - 1))
                begin
                    d.gen = ifcc_pkg::GEN_OWN;
                    d.scl_oe = 1'b1;
                    d.start_req = 1'b0;
                end
            end
            ifcc_pkg::GEN_OWN: d.gen = ifcc_pkg::GEN_OWN;
            default: d.gen = ifcc_pkg::GEN_IDLE;
        endcase
        if (!d.op_en)
        begin
            d.gen = ifcc_pkg::GEN_IDLE;
            d.sda_oe = 1'b0;
            d.scl_oe = 1'b0;
        end
    end

    // State register; reset clears every register to zero except the start generator state, which loads GEN_IDLE.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            q <= '0;
            q.gen <= ifcc_pkg::GEN_IDLE;
        end
        else
            q <= d;
    end

    assign prdata = q.prdata;
    assign pready = q.pready;
    assign pslverr = q.pslverr;
    assign scl_o = 1'b0;
    assign sda_o = 1'b0;
    assign scl_oe = q.scl_oe;
    assign sda_oe = q.sda_oe;
    assign clk_div = q.div;
    assign filt_on = q.filt;

    // Checks on the flag, level and start generator logic.
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    busy_ro_a: assert property (
        wr_flag && !q.busy && !start_p |=> !q.busy)
        else $error("busy flag set by a flag write");
    rsv_locked_a: assert property (
        wr_flag && q.op_en && !stop_p
            |=> $stable(q.rsv_dis) && $stable(q.init_start))
        else $error("locked flag bits changed while enabled");
    fail_cause_a: assert property (
        $rose(q.fail) |-> $past(q.rsv_dis && q.start_req && !allowed)
            && !q.start_req)
        else $error("fail flag set without a refused start");
    fail_clear_a: assert property (
        !q.op_en |=> !q.fail)
        else $error("fail flag kept while disabled");
    busy_start_a: assert property (
        start_p && q.op_en && d.op_en |=> q.busy)
        else $error("busy flag missed a start condition");
    busy_stop_a: assert property (
        stop_p && !start_p && !wr_ctrl |=> !q.busy)
        else $error("busy flag kept after a stop condition");
    start_gate_a: assert property (
        $rose(q.sda_oe) |-> $past(q.init_start || q.spd) && $past(!q.busy))
        else $error("start driven while not allowed");
    hold_time_a: assert property (
        $rose(q.sda_oe) ##1 q.op_en [*3] |-> !q.scl_oe)
        else $error("clock pulled before the start hold time");
    cld_track_a: assert property (
        q.op_en && scl_lvl ##1 q.op_en |-> ##0 q.cld && $past(scl_lvl))
        else $error("clock level bit does not follow the pin");
    dad_off_a: assert property (
        !q.op_en |=> !q.dad)
        else $error("data level bit set while disabled");

    start_made_c: cover property ($rose(q.scl_oe));
    fail_seen_c: cover property ($rose(q.fail));
    busy_enable_c: cover property (!q.op_en ##1 q.op_en && q.busy);
    stop_seen_c: cover property (stop_p && q.op_en);
endmodule
`default_nettype wire

// ===== testbench/i2c_flag_and_clock_config_bench.sv
// Self-checking bench for the flag and transfer clock registers.
`timescale 1ns/10ps
`default_nettype none
module i2c_flag_and_clock_config_bench;
    localparam int HALF_NS = ifcc_pkg::CLK_PERIOD_NS / 2;
    localparam logic [15:0] CTRL = ifcc_pkg::CTRL_IDX;
    localparam logic [15:0] STAT = ifcc_pkg::STAT_IDX;
    localparam logic [15:0] TCS = ifcc_pkg::TCS_IDX;
    localparam logic [15:0] FX = ifcc_pkg::FX_IDX;
    localparam logic [15:0] FLAG = ifcc_pkg::FLAG_IDX;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [17:0] paddr = 18'h00000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic scl_o;
    logic sda_o;
    logic scl_oe;
    logic sda_oe;
    logic [8:0] clk_div;
    logic filt_on;
    logic scl_pull;
    logic sda_pull;
    wire logic scl_w;
    wire logic sda_w;
    logic [7:0] rd;
    logic err;
    int bad_count = 0;
    int checks = 0;
    int n;

    // Clock of 100 ns period.
    always #(HALF_NS) pclk = ~pclk;

    // Open-drain lines with pull-ups: low when any party drives a zero.
    assign scl_w = (scl_oe ? scl_o : 1'b1) & !scl_pull;
    assign sda_w = (sda_oe ? sda_o : 1'b1) & !sda_pull;

    ifcc_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_i(scl_w),
        .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_w), .sda_o(sda_o),
        .sda_oe(sda_oe), .clk_div(clk_div), .filt_on(filt_on));
    ifcc_bus_peer peer (.pclk(pclk), .scl_pull(scl_pull), .sda_pull(sda_pull));

    // Prints the counts and the verdict, then ends the run.
    task automatic wrap_up();
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Compares a seen value with the expected one.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    // One APB transfer; waits for pready with no bound, then checks that it took one cycle.
    task automatic apb(input logic wr, input logic [15:0] idx,
        input logic [7:0] wd, output logic [7:0] rdv, output logic er);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h000000, wd};
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge pclk);
            k++;
        end
        while (pready !== 1'b1);
        check(32'(k), 32'h1);
        rdv = prdata[7:0];
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [15:0] idx, input logic [7:0] d);
        apb(1'b1, idx, d, rd, err);
    endtask

    task automatic rd_chk(input logic [15:0] idx, input logic [7:0] exp);
        apb(1'b0, idx, 8'h00, rd, err);
        check(32'(rd), 32'(exp));
    endtask

    // Expected cycles per transfer clock for speed, ext and select bits.
    function automatic logic [8:0] exp_div(input logic [4:0] c);
        if (c[4])
            return c[2] ? (c[0] ? 9'h030 : 9'h018) :
                (c[0] ? 9'h060 : 9'h030);
        if (c[2] || c[1:0] == 2'b11)
            return 9'h000;
        return c[1] ? 9'h158 : (c[0] ? 9'h0ac : 9'h058);
    endfunction

    // Cuts a hang short.
    initial
    begin
        repeat (20000) @(posedge pclk);
        bad_count++;
        wrap_up();
    end

    // Main sequence of tests.
    initial
    begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(TCS, 8'h00);
        rd_chk(FX, 8'h00);
        rd_chk(FLAG, 8'h00);
        apb(1'b0, 16'hffa7, 8'h00, rd, err);
        check(32'(err), 32'h1);
        check(32'(rd), 32'h0);
        // Writable and read-only bits while disabled.
        wr(TCS, 8'hff);
        rd_chk(TCS, 8'h0f);
        wr(FX, 8'hff);
        rd_chk(FX, 8'h01);
        wr(FLAG, 8'hff);
        rd_chk(FLAG, 8'h03);
        // Every speed, filter, extension and select combination.
        for (int i = 0; i < 32; i++)
        begin
            wr(TCS, {4'h0, i[4], i[3], i[1:0]});
            wr(FX, {7'h00, i[2]});
            repeat (2) @(posedge pclk);
            check(32'(clk_div), 32'(exp_div(i[4:0])));
            check(32'(filt_on), 32'(i[4] & i[3]));
        end
        // Enabling with initial start off marks the bus busy.
        wr(TCS, 8'h00);
        wr(FLAG, 8'h00);
        wr(CTRL, 8'h80);
        rd_chk(FLAG, 8'h40);
        wr(TCS, 8'h0f);
        wr(FLAG, 8'h03);
        rd_chk(TCS, 8'h30);
        rd_chk(FLAG, 8'h40);
        peer.start_cond();
        rd_chk(TCS, 8'h00);
        rd_chk(STAT, 8'h02);
        peer.stop_cond();
        rd_chk(FLAG, 8'h00);
        rd_chk(STAT, 8'h01);
        // Refused start with reservation off sets the fail flag.
        wr(CTRL, 8'h00);
        wr(FLAG, 8'h01);
        wr(CTRL, 8'h80);
        wr(CTRL, 8'h82);
        repeat (3) @(posedge pclk);
        rd_chk(FLAG, 8'hc1);
        rd_chk(CTRL, 8'h80);
        wr(CTRL, 8'h00);
        rd_chk(FLAG, 8'h01);
        // Initial start on: bus free at once, stop clears the bit.
        wr(FLAG, 8'h02);
        wr(CTRL, 8'h80);
        rd_chk(FLAG, 8'h02);
        peer.start_cond();
        peer.stop_cond();
        rd_chk(FLAG, 8'h00);
        wr(CTRL, 8'h00);
        // Own start with the bus idle: data low, then clock after the hold.
        wr(FLAG, 8'h02);
        wr(CTRL, 8'h80);
        wr(CTRL, 8'h82);
        n = 0;
        while (sda_oe !== 1'b1 && n < 20)
        begin
            @(posedge pclk);
            n++;
        end
        check(32'(sda_oe), 32'h1);
        n = 0;
        while (scl_oe !== 1'b1 && n < 100)
        begin
            @(posedge pclk);
            n++;
        end
        check(32'(n >= ifcc_pkg::HOLD_CYC - 2 &&
            n <= ifcc_pkg::HOLD_CYC + 2), 32'h1);
        check(32'({scl_o, sda_o}), 32'h0);
        repeat (8) @(posedge pclk);
        rd_chk(CTRL, 8'h80);
        rd_chk(STAT, 8'h02);
        rd_chk(FLAG, 8'h42);
        wr(CTRL, 8'h00);
        repeat (2) @(posedge pclk);
        check(32'({scl_oe, sda_oe}), 32'h0);
        rd_chk(FLAG, 8'h02);
        wrap_up();
    end
endmodule
`default_nettype wire

// ===== testbench/ifcc_bus_peer.sv
// Model of another party on the two open-drain bus lines.
`timescale 1ns/10ps
`default_nettype none
module ifcc_bus_peer (
    input wire logic pclk, // Peripheral clock that paces the line changes.
    output logic scl_pull, // High while the peer pulls the clock line low.
    output logic sda_pull // High while the peer pulls the data line low.
);
    localparam int HALF = 4; // Half of the 800 ns link clock period.

    // Lines stay released between frames, so the pull-ups hold them high.
    initial
    begin
        scl_pull = 1'b0;
        sda_pull = 1'b0;
    end

    // Lets a number of clock edges pass.
    task automatic pause(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // Data falls while the clock is high, then one clock pulse follows.
    task automatic start_cond();
        @(posedge pclk);
        sda_pull <= 1'b1;
        pause(HALF);
        scl_pull <= 1'b1;
        pause(HALF);
        scl_pull <= 1'b0;
        pause(HALF);
        scl_pull <= 1'b1;
        pause(HALF);
    endtask

    // Clock is released first, then data rises while the clock is high.
    task automatic stop_cond();
        scl_pull <= 1'b0;
        pause(HALF);
        sda_pull <= 1'b0;
        pause(HALF);
    endtask
endmodule
`default_nettype wire
